// File: verilog/gpio_port_pkg.sv
package gpio_port_pkg;

  // ****************************************************************
  // Register map (byte addresses on APB)
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_DIRECTION = 4'h0;
  localparam logic [3:0] OFS_VALUE = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_CONTROL = 4'hC;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int PORT_W = 8;
  localparam int BOOT_LSB = 0;
  localparam int BOOT_W = 3;
  localparam int PIN_SERIAL_A = 3;
  localparam int PIN_HANDSHAKE = 4;
  localparam int PIN_SERIAL_B = 5;
  localparam int PIN_SERIAL_SEL = 7;
  localparam int STAT_STRAP_SEL = 3;
  localparam int STAT_STRAP_VALID = 4;
  localparam int STAT_BOOT_DONE = 5;
  localparam int CTRL_BOOT_DONE = 0;
  localparam logic [7:0] DIRECTION_RST = 8'h00;
  localparam logic [7:0] VALUE_RST = 8'h00;

  // ****************************************************************
  // Timing: strap sampling waits for the pin synchroniser to fill
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  // Boot codes that use the handshake pin (one bit per code)
  localparam logic [7:0] HANDSHAKE_MODES = 8'hF0;

endpackage

// File: verilog/pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic cen_i, // Clock enable
  input wire logic [WIDTH-1:0] pin_i, // Raw pin levels
  output logic [WIDTH-1:0] sync_o // Synchronised levels
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (cen_i) begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

// File: verilog/strap_capture.sv
module strap_capture (
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic cen_i, // Clock enable
  input wire logic [7:0] pin_sync_i, // Synchronised pin levels
  output logic valid_o, // Straps have been taken
  output logic [2:0] boot_code_o, // Captured boot-mode code
  output logic serial_sel_o // Captured serial-function strap
);

  logic [1:0] settle_reg;
  logic valid_reg;
  logic [2:0] code_reg;
  logic sel_reg;
  logic take;

  // Take the straps once the synchroniser holds post-release levels
  assign take = !valid_reg && (settle_reg == gpio_port_pkg::STRAP_SETTLE_CYCLES);

  // Settle counter, then one-time capture held until next reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      settle_reg <= 2'h0;
      valid_reg <= 1'b0;
      code_reg <= 3'h0;
      sel_reg <= 1'b0;
    end else if (cen_i) begin
      if (!valid_reg && !take) begin
        settle_reg <= settle_reg + 2'h1;
      end
      if (take) begin
        valid_reg <= 1'b1;
        code_reg <= pin_sync_i[2:0];
        sel_reg <= pin_sync_i[gpio_port_pkg::PIN_SERIAL_SEL];
      end
    end
  end

  assign valid_o = valid_reg;
  assign boot_code_o = code_reg;
  assign serial_sel_o = sel_reg;

endmodule

// File: verilog/gpio_port_boot_strap_mux.sv
module gpio_port_boot_strap_mux #(
  parameter int PORT_W = gpio_port_pkg::PORT_W,
  parameter logic [7:0] HANDSHAKE_MODES = gpio_port_pkg::HANDSHAKE_MODES
) (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic nrst_i, // Async reset, active low
  input wire logic cen_i, // Clock enable, freezes state
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [3:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  input wire logic [7:0] gpio_in_i, // Pin levels from pads
  output logic [7:0] gpio_out_o, // Pin drive levels
  output logic [7:0] gpio_oe_o, // Pin output enables
  input wire logic boot_handshake_i, // Handshake level from boot loader
  input wire logic serial2_tx_clock_i, // Serial port transmit clock
  input wire logic serial2_tx_frame_sync_i, // Serial port frame sync
  output logic [2:0] boot_select_strap_o, // Captured boot-mode code
  output logic strap_valid_o, // Boot code captured
  output logic boot_active_o // Bootload in progress
);

  // ****************************************************************
  // Pin synchronisation and strap capture
  // ****************************************************************
  logic [7:0] pin_sync;
  logic strap_valid;
  logic [2:0] boot_code;
  logic serial_sel;

  pin_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .cen_i(cen_i),
    .pin_i(gpio_in_i),
    .sync_o(pin_sync)
  );

  strap_capture u_strap (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .cen_i(cen_i),
    .pin_sync_i(pin_sync),
    .valid_o(strap_valid),
    .boot_code_o(boot_code),
    .serial_sel_o(serial_sel)
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] port_direction_reg;
  logic [7:0] port_value_reg;
  logic boot_done_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [7:0] out_reg;
  logic [7:0] oe_reg;
  logic [2:0] strap_out_reg;
  logic strap_valid_reg;
  logic boot_active_reg;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic hit_direction;
  logic hit_value;
  logic hit_status;
  logic hit_control;
  logic addr_mapped;
  logic [7:0] value_readback;
  logic [7:0] status_word;
  logic [31:0] read_data;
  // Write strobes and per-register read words
  logic wr_direction;
  logic wr_value;
  logic wr_control;
  logic [31:0] rd_direction_word;
  logic [31:0] rd_value_word;
  logic [31:0] rd_status_word;
  logic [31:0] rd_control_word;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // One-hot pin mask for a bit position
  function automatic logic [7:0] pin_mask(input int pos);
    logic [7:0] mask;
    mask = 8'h00;
    mask[pos] = 1'b1;
    return mask;
  endfunction

  // Byte address matches a register offset
  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
    return addr == ofs;
  endfunction

  // Zero-extend a byte-wide register view to the bus word
  function automatic logic [31:0] word_of(input logic [7:0] field);
    return {24'h0, field};
  endfunction

  // Setup and completing-access strobes
  assign setup_phase = psel_i && !penable_i;
  assign access_done = psel_i && penable_i && pready_reg;
  assign wr_done = access_done && pwrite_i;

  // Exact decode of all four byte-address bits
  assign hit_direction = reg_hit(paddr_i, gpio_port_pkg::OFS_DIRECTION);
  assign hit_value = reg_hit(paddr_i, gpio_port_pkg::OFS_VALUE);
  assign hit_status = reg_hit(paddr_i, gpio_port_pkg::OFS_STATUS);
  assign hit_control = reg_hit(paddr_i, gpio_port_pkg::OFS_CONTROL);
  assign addr_mapped = hit_direction || hit_value || hit_status || hit_control;

  // ****************************************************************
  // Register write strobes
  // ****************************************************************
  assign wr_direction = wr_done && hit_direction;
  assign wr_value = wr_done && hit_value;
  assign wr_control = wr_done && hit_control;

  // Inputs show pin level, outputs show latched value
  assign value_readback = (port_direction_reg & port_value_reg)
                        | (~port_direction_reg & pin_sync);

  // Strap and boot state view, bit positions from the package
  always_comb begin
    status_word = 8'h00;
    status_word[gpio_port_pkg::BOOT_LSB +: gpio_port_pkg::BOOT_W] = boot_code;
    status_word[gpio_port_pkg::STAT_STRAP_SEL] = serial_sel;
    status_word[gpio_port_pkg::STAT_STRAP_VALID] = strap_valid;
    status_word[gpio_port_pkg::STAT_BOOT_DONE] = boot_done_reg;
  end

  // Per-register read words
  assign rd_direction_word = word_of(port_direction_reg);
  assign rd_value_word = word_of(value_readback);
  assign rd_status_word = word_of(status_word);
  assign rd_control_word = {31'h0, boot_done_reg};

  // Read mux; unmapped reads return zero
  assign read_data = hit_direction ? rd_direction_word :
                     hit_value ? rd_value_word :
                     hit_status ? rd_status_word :
                     hit_control ? rd_control_word : 32'h0;

  // APB answer: ready one cycle after setup, zero wait in access
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else if (cen_i) begin
      if (setup_phase) begin
        pready_reg <= 1'b1;
        pslverr_reg <= !addr_mapped;
        prdata_reg <= pwrite_i ? 32'h0 : read_data;
      end else begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Software-visible port state
  // ****************************************************************

  // Direction and value registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_direction_reg <= gpio_port_pkg::DIRECTION_RST;
      port_value_reg <= gpio_port_pkg::VALUE_RST;
    end else if (cen_i) begin
      if (wr_direction) begin
        port_direction_reg <= pwdata_i[7:0];
      end
      if (wr_value) begin
        port_value_reg <= pwdata_i[7:0];
      end
    end
  end

  // Boot completion flag, set by the loaded program, sticky
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      boot_done_reg <= 1'b0;
    end else if (cen_i) begin
      if (wr_control && pwdata_i[gpio_port_pkg::CTRL_BOOT_DONE]) begin
        boot_done_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Pin function selection
  // ****************************************************************
  logic booting;
  logic handshake_on;
  logic serial_on;
  logic [7:0] port_oe;
  logic [7:0] pin_oe_next;
  logic [7:0] pin_out_next;
  logic [7:0] serial_mask;
  logic [7:0] boot_pins;
  logic [7:0] serial_pins;

  // Boot-mode pins, held as inputs while the loader runs
  assign boot_pins = pin_mask(gpio_port_pkg::BOOT_LSB)
                   | pin_mask(gpio_port_pkg::BOOT_LSB + 1)
                   | pin_mask(gpio_port_pkg::BOOT_LSB + 2);

  // Shared pins that the serial port can take over
  assign serial_pins = pin_mask(gpio_port_pkg::PIN_SERIAL_A)
                     | pin_mask(gpio_port_pkg::PIN_SERIAL_B);

  // Bootload window and handshake-using boot modes
  assign booting = strap_valid && !boot_done_reg;
  assign handshake_on = booting && HANDSHAKE_MODES[boot_code];
  assign serial_on = strap_valid && serial_sel;

  // Serial-owned bits are removed from port control
  assign serial_mask = serial_on ? serial_pins : 8'h00;

  // All pins held as inputs until straps are taken, boot pins until boot done
  assign port_oe = !strap_valid ? 8'h00 :
                   booting ? (port_direction_reg & ~boot_pins) :
                   port_direction_reg;

  // Output enable per pin
  always_comb begin
    pin_oe_next = port_oe & ~serial_mask;
    pin_out_next = port_value_reg & ~serial_mask;
    if (serial_on) begin
      pin_oe_next[gpio_port_pkg::PIN_SERIAL_A] = 1'b1;
      pin_out_next[gpio_port_pkg::PIN_SERIAL_A] = serial2_tx_clock_i;
      pin_oe_next[gpio_port_pkg::PIN_SERIAL_B] = 1'b1;
      pin_out_next[gpio_port_pkg::PIN_SERIAL_B] = serial2_tx_frame_sync_i;
    end
    if (handshake_on) begin
      pin_oe_next[gpio_port_pkg::PIN_HANDSHAKE] = 1'b1;
      pin_out_next[gpio_port_pkg::PIN_HANDSHAKE] = boot_handshake_i;
    end
  end

  // Registered pin drive and status outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_reg <= 8'h00;
      oe_reg <= 8'h00;
      strap_out_reg <= 3'h0;
      strap_valid_reg <= 1'b0;
      boot_active_reg <= 1'b0;
    end else if (cen_i) begin
      out_reg <= pin_out_next;
      oe_reg <= pin_oe_next;
      strap_out_reg <= boot_code;
      strap_valid_reg <= strap_valid;
      boot_active_reg <= booting;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign gpio_out_o = out_reg;
  assign gpio_oe_o = oe_reg;
  assign boot_select_strap_o = strap_out_reg;
  assign strap_valid_o = strap_valid_reg;
  assign boot_active_o = boot_active_reg;

endmodule

// File: sim/gpio_port_props.sv
module gpio_port_props #(
  parameter logic [7:0] HANDSHAKE_MODES = 8'hF0
) (
  input wire logic clk_i, // Clock
  input wire logic nrst_i, // Reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pready_o, // APB ready
  input wire logic pslverr_o, // APB error
  input wire logic [7:0] gpio_out_o, // Pin levels
  input wire logic [7:0] gpio_oe_o, // Pin enables
  input wire logic boot_handshake_i, // Handshake level
  input wire logic [2:0] boot_select_strap_o, // Boot code
  input wire logic strap_valid_o, // Straps taken
  input wire logic boot_active_o // Bootload running
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ****************************************************************
  // Bus handshake and pin ownership
  // ****************************************************************
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence answer_s;
    pready_o ##1 !pready_o;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> answer_s)
    else $error("ready missing after setup");
  a_ready_has_cause: assert property (pready_o |-> $past(psel_i) && !$past(penable_i))
    else $error("ready without setup");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error outside access");
  a_no_drive_early: assert property (!strap_valid_o |-> gpio_oe_o == 8'h00)
    else $error("pin driven before straps");
  a_boot_pins_input: assert property (boot_active_o |-> gpio_oe_o[2:0] == 3'h0)
    else $error("boot pins driven in boot");
  a_strap_held: assert property ($past(strap_valid_o) |-> $stable(boot_select_strap_o))
    else $error("boot code changed");
  a_valid_sticky: assert property (strap_valid_o |=> strap_valid_o)
    else $error("strap valid dropped");
  a_boot_needs_strap: assert property (boot_active_o |-> strap_valid_o)
    else $error("boot without straps");
  a_handshake_drive: assert property (boot_active_o && $past(boot_active_o)
    && HANDSHAKE_MODES[boot_select_strap_o]
    |-> gpio_oe_o[4] && gpio_out_o[4] == $past(boot_handshake_i))
    else $error("handshake pin wrong");
endmodule

bind gpio_port_boot_strap_mux gpio_port_props #(.HANDSHAKE_MODES(HANDSHAKE_MODES)) u_props (.*);

// File: sim/board_model.sv
module board_model (
  input wire logic [7:0] gpio_out_i, // Device levels
  input wire logic [7:0] gpio_oe_i, // Device enables
  input wire logic [7:0] drive_i, // Board levels
  output logic [7:0] pad_o // Resolved pads
);
  timeunit 1ns;
  timeprecision 100ps;
  // Driven pins show the device level, the rest the board level
  assign pad_o = (gpio_out_i & gpio_oe_i) | (drive_i & ~gpio_oe_i);
endmodule

// File: sim/gpio_port_boot_strap_mux_test.sv
module gpio_port_boot_strap_mux_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0, nrst_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic [3:0] paddr_i = 4'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, strap_valid_o, boot_active_o, cen_i = 1'h1;
  logic [7:0] gpio_in_i, gpio_out_o, gpio_oe_o, drv = 8'h00, d, v;
  logic [2:0] boot_select_strap_o, ser = 3'h0, ser_p = 3'h0;
  logic [32:0] exp_q[$];
  int seed = 34, n_fail = 0, cmp_count = 0;
  // ****************************************************************
  // Design, board and stimulus helpers
  // ****************************************************************
  gpio_port_boot_strap_mux u_gpio_port_boot_strap_mux (.*, .cen_i(cen_i),
    .serial2_tx_clock_i(ser[0]), .serial2_tx_frame_sync_i(ser[1]), .boot_handshake_i(ser[2]));
  board_model u_board_model (.gpio_out_i(gpio_out_o), .gpio_oe_i(gpio_oe_o), .drive_i(drv),
    .pad_o(gpio_in_i));
  initial forever #5 clk_i = ~clk_i;
  // Serial and handshake levels change every cycle
  always @(posedge clk_i) begin
    ser_p <= ser;
    ser <= 3'($random(seed));
  end
  task check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Read answers compared against the oldest note
  always @(negedge clk_i) if (pready_o === 1'h1 && pwrite_i === 1'h0)
    check("read", {pslverr_o, prdata_o}, exp_q.pop_front());
  task apb(input logic w, input logic [3:0] a, input logic [31:0] dat);
    @(posedge clk_i);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= dat;
    @(posedge clk_i);
    penable_i <= 1'h1;
    do begin
      @(negedge clk_i);
    end while (pready_o !== 1'h1);
    @(posedge clk_i);
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task rd(input logic [3:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'h0, a, 32'h0);
  endtask
  task pins(input logic [7:0] oe_e, input logic [7:0] out_e, input logic [7:0] m,
            input logic s, input logic h);
    logic [7:0] e;
    repeat (3) @(negedge clk_i);
    e = out_e;
    if (s) begin
      e[3] = ser_p[0];
      e[5] = ser_p[1];
    end
    if (h) e[4] = ser_p[2];
    check("oe", {25'h0, gpio_oe_o}, {25'h0, oe_e});
    check("out", {25'h0, gpio_out_o & m}, {25'h0, e & m});
  endtask
  task rst(input logic [7:0] st);
    drv <= st;
    nrst_i <= 1'h0;
    repeat (16) @(posedge clk_i);
    check("oe_rst", {25'h0, gpio_oe_o}, 33'h0);
    nrst_i <= 1'h1;
    while (strap_valid_o !== 1'h1) begin
      @(negedge clk_i);
    end
    check("code", {30'h0, boot_select_strap_o}, {30'h0, st[2:0]});
  endtask
  task results();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    results();
  end
  // Main sequence: serial strap boot, then plain port with random traffic
  initial begin
    rst(8'h85);
    check("active", {32'h0, boot_active_o}, 33'h1);
    pins(8'h38, 8'h00, 8'h38, 1'h1, 1'h1);
    rd(gpio_port_pkg::OFS_STATUS, 33'h1D);
    rd(gpio_port_pkg::OFS_DIRECTION, 33'h0);
    drv <= 8'h00;
    apb(1'h1, gpio_port_pkg::OFS_DIRECTION, 32'hFF);
    pins(8'hF8, 8'h00, 8'hF8, 1'h1, 1'h1);
    rd(gpio_port_pkg::OFS_STATUS, 33'h1D);
    apb(1'h1, gpio_port_pkg::OFS_CONTROL, 32'h1);
    apb(1'h1, gpio_port_pkg::OFS_VALUE, 32'h10);
    pins(8'hFF, 8'h10, 8'hFF, 1'h1, 1'h0);
    check("active", {32'h0, boot_active_o}, 33'h0);
    // Clock enable low: serial pins hold while their sources move
    @(posedge clk_i);
    cen_i <= 1'h0;
    @(negedge clk_i);
    d = gpio_out_o;
    repeat (4) @(negedge clk_i);
    check("frozen", {25'h0, gpio_out_o}, {25'h0, d});
    @(posedge clk_i);
    cen_i <= 1'h1;
    rd(gpio_port_pkg::OFS_STATUS, 33'h3D);
    rst(8'h02);
    apb(1'h1, gpio_port_pkg::OFS_CONTROL, 32'h1);
    drv <= 8'($random(seed));
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      v = 8'($random(seed));
      apb(1'h1, gpio_port_pkg::OFS_DIRECTION, {24'h0, d});
      apb(1'h1, gpio_port_pkg::OFS_VALUE, {24'h0, v});
      pins(d, v, d, 1'h0, 1'h0);
      rd(gpio_port_pkg::OFS_VALUE, {25'h0, (v & d) | (drv & ~d)});
    end
    rd(4'h2, 33'h100000000);
    apb(1'h1, gpio_port_pkg::OFS_STATUS, 32'h0);
    rd(gpio_port_pkg::OFS_STATUS, 33'h32);
    results();
  end
endmodule
